/* File: hw/pieb_pkg.sv */
package pieb_pkg;
    localparam int PIEB_NUM_SRC = 12;
    localparam int PIEB_ADDR_W = 8;

    // Register byte offsets
    localparam logic [7:0] PIEB_OFS_ENABLE_A = 8'h00;
    localparam logic [7:0] PIEB_OFS_ENABLE_B = 8'h04;
    localparam logic [7:0] PIEB_OFS_FLAGS = 8'h08;
    localparam logic [7:0] PIEB_OFS_CTRL = 8'h0c;
    localparam logic [7:0] PIEB_OFS_PRIORITY = 8'h10;
    localparam logic [7:0] PIEB_OFS_PENDING = 8'h14;

    // Reset values
    localparam logic [7:0] PIEB_RST_ENABLE_A = 8'h00;
    localparam logic [3:0] PIEB_RST_ENABLE_B = 4'h0;
    localparam logic [11:0] PIEB_RST_FLAGS = 12'h000;
    localparam logic [11:0] PIEB_RST_PRIORITY = 12'hfff;

    // Field positions in the first enable register and flag word
    localparam int PIEB_BIT_PARALLEL_SLAVE = 7;
    localparam int PIEB_BIT_CONVERTER = 6;
    localparam int PIEB_BIT_SERIAL_RX = 5;
    localparam int PIEB_BIT_SERIAL_TX = 4;
    localparam int PIEB_BIT_SYNC_SERIAL = 3;
    localparam int PIEB_BIT_CAPCOMP_ONE = 2;
    localparam int PIEB_BIT_TIMER_TWO = 1;
    localparam int PIEB_BIT_TIMER_ONE = 0;
    // Field positions in the second enable register
    localparam int PIEB_BIT_BUS_COLLISION = 3;
    localparam int PIEB_BIT_LOW_VOLTAGE = 2;
    localparam int PIEB_BIT_TIMER_THREE = 1;
    localparam int PIEB_BIT_CAPCOMP_TWO = 0;
    // Second-register sources sit above the first byte in the flag word
    localparam int PIEB_B_BASE = 8;
    localparam int PIEB_B_WIDTH = 4;

    // Control register fields
    localparam int PIEB_CTRL_GLOBAL_BIT = 0;
    localparam int PIEB_CTRL_PRIO_BIT = 1;
    localparam logic PIEB_RST_GLOBAL = 1'b0;
    localparam logic PIEB_RST_PRIO = 1'b0;

    typedef struct packed {
        logic priority_mode_enable;
        logic global_peripheral_enable;
    } pieb_ctrl_s;

    typedef struct packed {
        logic irq;
        logic irq_high;
        logic irq_low;
    } pieb_irq_s;
endpackage : pieb_pkg

/* File: hw/pieb_top.sv */
// The address map and the APB slave port were decided locally.
`timescale 1ns/100ps
module pieb_top
    import pieb_pkg::*;
#(
    parameter int NUM_SRC = PIEB_NUM_SRC
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [NUM_SRC-1:0] periph_event,
    output logic [NUM_SRC-1:0] periph_flags,
    output pieb_irq_s periph_irq
);

    logic [7:0] enable_a_r;
    logic [PIEB_B_WIDTH-1:0] enable_b_r;
    logic [NUM_SRC-1:0] flags_r;
    logic [NUM_SRC-1:0] priority_r;
    pieb_ctrl_s ctrl_r;
    logic [31:0] prdata_r;
    logic pslverr_r;
    logic [NUM_SRC-1:0] enable_vec;
    logic [NUM_SRC-1:0] pending;
    logic [NUM_SRC-1:0] flags_nxt;
    logic setup_ph;
    logic wr_acc;
    logic addr_ok;
    logic [7:0] addr_lo;
    logic [NUM_SRC-1:0] w1c_mask;
    pieb_irq_s irq_nxt;

    function automatic logic any_req(input logic [NUM_SRC-1:0] fl,
                                     input logic [NUM_SRC-1:0] en);
        any_req = |(fl & en);
    endfunction : any_req

    function automatic logic is_mapped(input logic [7:0] a);
        is_mapped = (a == PIEB_OFS_ENABLE_A) || (a == PIEB_OFS_ENABLE_B) ||
                    (a == PIEB_OFS_FLAGS) || (a == PIEB_OFS_CTRL) ||
                    (a == PIEB_OFS_PRIORITY) || (a == PIEB_OFS_PENDING);
    endfunction : is_mapped

    assign addr_lo = paddr[7:0];
    assign addr_ok = is_mapped(addr_lo) && (paddr[31:8] == 24'h000000);
    assign setup_ph = psel && !penable;
    assign wr_acc = psel && penable && pwrite && addr_ok && pstrb[0];

    // Zero-wait slave: every access phase completes in one cycle
    assign pready = 1'b1;
    assign prdata = prdata_r;
    assign pslverr = pslverr_r;

    assign enable_vec = {enable_b_r, enable_a_r};

    assign pending = flags_r & enable_vec;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            enable_a_r <= PIEB_RST_ENABLE_A;
        end else if (wr_acc && addr_lo == PIEB_OFS_ENABLE_A) begin
            enable_a_r <= pwdata[7:0];
        end
    end

    // timer three gate at bit 1
    // capcomp two gate at bit 0
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            enable_b_r <= PIEB_RST_ENABLE_B;
        end else if (wr_acc && addr_lo == PIEB_OFS_ENABLE_B) begin
            enable_b_r[PIEB_BIT_BUS_COLLISION] <= pwdata[PIEB_BIT_BUS_COLLISION];
            enable_b_r[PIEB_BIT_LOW_VOLTAGE] <= pwdata[PIEB_BIT_LOW_VOLTAGE];
            enable_b_r[PIEB_BIT_TIMER_THREE] <= pwdata[PIEB_BIT_TIMER_THREE];
            enable_b_r[PIEB_BIT_CAPCOMP_TWO] <= pwdata[PIEB_BIT_CAPCOMP_TWO];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_r.global_peripheral_enable <= PIEB_RST_GLOBAL;
            ctrl_r.priority_mode_enable <= PIEB_RST_PRIO;
        end else if (wr_acc && addr_lo == PIEB_OFS_CTRL) begin
            ctrl_r.global_peripheral_enable <= pwdata[PIEB_CTRL_GLOBAL_BIT];
            ctrl_r.priority_mode_enable <= pwdata[PIEB_CTRL_PRIO_BIT];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            priority_r <= PIEB_RST_PRIORITY;
        end else if (wr_acc && addr_lo == PIEB_OFS_PRIORITY) begin
            priority_r <= pwdata[NUM_SRC-1:0];
        end
    end

    // Write-one-to-clear; a same-cycle event keeps the flag set
    assign w1c_mask = (wr_acc && addr_lo == PIEB_OFS_FLAGS) ?
                      pwdata[NUM_SRC-1:0] : '0;

    assign flags_nxt = (flags_r & ~w1c_mask) | periph_event;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flags_r <= PIEB_RST_FLAGS;
        end else begin
            flags_r <= flags_nxt;
        end
    end

    assign periph_flags = flags_r;

    // priority split only in priority mode
    always_comb begin
        irq_nxt = '0;
        if (ctrl_r.priority_mode_enable) begin
            irq_nxt.irq_high = any_req(pending, priority_r);
            irq_nxt.irq_low = any_req(pending, ~priority_r);
            irq_nxt.irq = irq_nxt.irq_high || irq_nxt.irq_low;
        end else begin
            irq_nxt.irq = any_req(flags_r, enable_vec) &&
                          ctrl_r.global_peripheral_enable;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            periph_irq <= '0;
        end else begin
            periph_irq <= irq_nxt;
        end
    end

    // Read data captured in the setup cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_r <= 32'h00000000;
        end else if (setup_ph) begin
            prdata_r <= 32'h00000000;
            if (!pwrite && addr_ok) begin
                unique case (addr_lo)
                    PIEB_OFS_ENABLE_A: prdata_r[7:0] <= enable_a_r;
                    PIEB_OFS_ENABLE_B: prdata_r[PIEB_B_WIDTH-1:0] <= enable_b_r;
                    PIEB_OFS_FLAGS: prdata_r[NUM_SRC-1:0] <= flags_r;
                    PIEB_OFS_CTRL: prdata_r[1:0] <= ctrl_r;
                    PIEB_OFS_PRIORITY: prdata_r[NUM_SRC-1:0] <= priority_r;
                    PIEB_OFS_PENDING: prdata_r[NUM_SRC-1:0] <= pending;
                    default: prdata_r <= 32'h00000000;
                endcase
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pslverr_r <= 1'b0;
        end else if (setup_ph) begin
            pslverr_r <= !addr_ok;
        end
    end

endmodule : pieb_top

/* File: sim/pieb_props.sv */
`timescale 1ns/100ps
module pieb_props
    import pieb_pkg::*;
#(
    parameter int NUM_SRC = PIEB_NUM_SRC
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic pslverr,
    input wire logic [NUM_SRC-1:0] periph_event,
    input wire logic [NUM_SRC-1:0] periph_flags,
    input wire pieb_irq_s periph_irq
);
    logic wr_clr;
    assign wr_clr = psel && penable && pwrite && pstrb[0] && paddr == {24'h0, PIEB_OFS_FLAGS};
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_event_sets_flag: assert property (
        periph_event != '0 |=> (periph_flags & $past(periph_event)) == $past(periph_event))
        else $error("event did not set flag");
    a_flag_sticky: assert property (
        !wr_clr |=> (periph_flags & $past(periph_flags)) == $past(periph_flags))
        else $error("flag dropped without clear");
    a_flag_cleared: assert property (
        wr_clr |=> (periph_flags & $past(pwdata[NUM_SRC-1:0] & ~periph_event)) == '0)
        else $error("flag not cleared");
    a_no_stray_flag: assert property (
        (periph_flags & ~$past(periph_flags) & ~$past(periph_event)) == '0)
        else $error("flag set without event");
    a_irq_has_cause: assert property (
        periph_irq.irq |-> $past(periph_flags) != '0)
        else $error("irq without flag");
    a_quiet_no_irq: assert property (
        periph_flags == '0 |=> !periph_irq.irq)
        else $error("irq stayed with no flag");
    a_prio_implies_irq: assert property (
        (periph_irq.irq_high || periph_irq.irq_low) |-> periph_irq.irq)
        else $error("priority line without irq");
    a_unmapped_err: assert property (
        psel && penable && paddr[31:8] != 24'h0 |-> pslverr)
        else $error("unmapped access without error");
endmodule : pieb_props
bind pieb_top pieb_props #(.NUM_SRC(NUM_SRC)) pieb_props_i (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .pslverr(pslverr), .periph_event(periph_event),
    .periph_flags(periph_flags), .periph_irq(periph_irq));

/* File: sim/tb_top.sv */
`timescale 1ns/100ps
module tb_top import pieb_pkg::*;;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, rd;
    logic [3:0] pstrb = 4'hf;
    logic [23:0] hi = 24'h0;
    logic pready, pslverr, er;
    logic [11:0] periph_event = 12'h000, periph_flags;
    pieb_irq_s periph_irq;
    int miscompares = 0, n_tests = 0;
    always #25 pclk = ~pclk;
    pieb_top pieb_top_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .periph_event(periph_event),
        .periph_flags(periph_flags), .periph_irq(periph_irq));
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {hi, a};
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic wen(input logic [11:0] m);
        apb(1'b1, PIEB_OFS_ENABLE_A, {24'h0, m[7:0]});
        apb(1'b1, PIEB_OFS_ENABLE_B, {28'h0, m[11:8]});
    endtask : wen
    task automatic pulse(input logic [11:0] m);
        @(posedge pclk);
        periph_event <= m;
        @(posedge pclk);
        periph_event <= 12'h000;
        repeat (3) @(posedge pclk);
    endtask : pulse
    task automatic t_regs;
        apb(1'b0, PIEB_OFS_ENABLE_A, 32'h0);
        chk("enable_a reset", 32'h0, rd);
        apb(1'b0, PIEB_OFS_PRIORITY, 32'h0);
        chk("priority reset", 32'hfff, rd);
        apb(1'b1, PIEB_OFS_ENABLE_B, 32'hffffffff);
        apb(1'b0, PIEB_OFS_ENABLE_B, 32'h0);
        chk("enable_b width", 32'hf, rd);
        pstrb <= 4'he;
        apb(1'b1, PIEB_OFS_ENABLE_A, 32'hff);
        pstrb <= 4'hf;
        apb(1'b0, PIEB_OFS_ENABLE_A, 32'h0);
        chk("enable_a lane off", 32'h0, rd);
        apb(1'b0, 8'h18, 32'h0);
        chk("unmapped low error", 32'h1, {31'h0, er});
        hi <= 24'h1;
        apb(1'b0, PIEB_OFS_ENABLE_A, 32'h0);
        hi <= 24'h0;
        chk("unmapped high error", 32'h1, {31'h0, er});
        chk("unmapped data", 32'h0, rd);
        $display("test regs done");
    endtask : t_regs
    task automatic t_gate;
        logic [11:0] m;
        apb(1'b1, PIEB_OFS_CTRL, 32'h1);
        for (int i = 0; i < 12; i++) begin
            m = 12'h001 << i;
            wen(~m);
            pulse(m);
            chk("flag held", {20'h0, m}, {20'h0, periph_flags});
            chk("irq masked", 32'h0, {31'h0, periph_irq.irq});
            wen(m);
            repeat (2) @(posedge pclk);
            chk("irq enabled", 32'h1, {31'h0, periph_irq.irq});
            apb(1'b0, PIEB_OFS_PENDING, 32'h0);
            chk("pending word", {20'h0, m}, rd);
            apb(1'b1, PIEB_OFS_FLAGS, {20'h0, m});
            repeat (2) @(posedge pclk);
            chk("flag cleared", 32'h0, {20'h0, periph_flags});
        end
        $display("test gate done");
    endtask : t_gate
    task automatic t_global;
        apb(1'b1, PIEB_OFS_CTRL, 32'h0);
        pulse(12'h800);
        chk("irq global off", 32'h0, {29'h0, periph_irq});
        apb(1'b1, PIEB_OFS_CTRL, 32'h2);
        repeat (2) @(posedge pclk);
        chk("irq high prio", 32'h6, {29'h0, periph_irq});
        apb(1'b1, PIEB_OFS_PRIORITY, 32'h0);
        repeat (2) @(posedge pclk);
        chk("irq low prio", 32'h5, {29'h0, periph_irq});
        $display("test global done");
    endtask : t_global
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : give_verdict
    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        t_regs;
        t_gate;
        t_global;
        give_verdict;
    end
    initial begin
        #100000;
        miscompares++;
        give_verdict;
    end
endmodule : tb_top
